// >>> logic/pbha_top.sv
// Purpose: host access to the packet buffer and pointer checks
// Assumes: host pins asynchronous, control inputs on ref_clk_in
// Notes: strobes act two to three cycles after the pin edge
`include "pbha_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module pbha_top (
    input  wire logic        ref_clk_in,            // 100 MHz clock
    input  wire logic        rst_in,                // async reset, high
    input  wire logic        host_cs_n_in,          // chip select pin, low
    input  wire logic        host_rd_n_in,          // read strobe pin, low
    input  wire logic        host_wr_n_in,          // write strobe pin, low
    input  wire logic [5:0]  host_addr_in,          // register offset pins
    input  wire logic [15:0] host_data_in,          // data bus input
    input  wire logic        wide_bus_select_in,    // pin, high for 16 bit
    input  wire logic        byte_swap_n_in,        // pin, low to swap
    input  wire logic        word_access_mode_in,   // word mode bit
    input  wire logic [1:0]  page_size_field_in,    // page size code
    input  wire logic [4:0]  own_node_id_in,        // own node id
    input  wire logic        transmit_mode_select_in, // 1 remote buffer
    input  wire logic        single_shot_send_in,   // 1 one packet/cmd
    input  wire logic        send_command_in,       // send pulse
    input  wire logic        token_arrival_in,      // token pulse
    input  wire logic        tx_done_in,            // packet sent pulse
    input  wire logic        error_clear_in,        // clear both errors
    input  wire logic        rx_header_valid_in,    // rx pointer valid
    input  wire logic [7:0]  rx_pointer_in,         // received pointer
    output logic      [15:0] host_data_out,         // data bus output
    output logic             host_data_oe_out,      // data bus enable
    output logic             send_error_flag_out,   // sticky send error
    output logic             pointer_error_flag_out, // sticky ptr error
    output logic             transmitter_available_flag_out, // idle
    output logic             tx_request_out,        // start sending
    output logic             token_pass_out,        // pass token pulse
    output logic             broadcast_out,         // destination zero
    output logic      [7:0]  source_node_out,       // header source
    output logic      [7:0]  destination_node_out,  // header dest
    output logic             rx_discard_out,        // rx dropped pulse
    output logic             rx_accept_out          // rx kept pulse
);
    import pbha_pkg::*;

    pbha_ram_if ram_bus ();
    pbha_ram u_ram (.ref_clk_in(ref_clk_in), .ram(ram_bus.mem));

    // two stage synchroniser for every host pin
    logic [26:0] pin_s1_q, pin_s2_q;
    logic        rd_prev_q, wr_prev_q, rd_now, wr_now;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q  <= 27'h7ffffff;
            pin_s2_q  <= 27'h7ffffff;
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            pin_s1_q  <= {wide_bus_select_in, byte_swap_n_in, host_cs_n_in, host_rd_n_in,
                          host_wr_n_in, host_addr_in, host_data_in};
            pin_s2_q  <= pin_s1_q;
            rd_prev_q <= rd_now;
            wr_prev_q <= wr_now;
        end
    end

    logic [15:0] d_s;
    logic [5:0]  a_s;
    logic        rd_go, wr_go, wide, swap, wmode;
    assign d_s    = pin_s2_q[15:0];
    assign a_s    = pin_s2_q[21:16];
    assign wr_now = ~pin_s2_q[24] & ~pin_s2_q[22];
    assign rd_now = ~pin_s2_q[24] & ~pin_s2_q[23];
    assign rd_go  = rd_now & ~rd_prev_q;
    assign wr_go  = wr_now & ~wr_prev_q;
    assign swap   = ~pin_s2_q[25];
    assign wide   = pin_s2_q[26];
    assign wmode  = wide | word_access_mode_in;

    logic [7:0] page_q, off_q, hold_q;

    // offset decode; swap moves the control registers up by one
    logic sel_page, sel_addr, sel_data, sel_low;
    assign sel_page = (a_s == (swap ? `PBHA_OFF_PAGE_SW : `PBHA_OFF_PAGE)); // [R4]
    assign sel_addr = (a_s == (swap ? `PBHA_OFF_ADDR_SW : `PBHA_OFF_ADDR)); // [R5]
    assign sel_data = (a_s == `PBHA_OFF_DATA_LO) | (a_s == `PBHA_OFF_DATA_HI); // [R8]
    assign sel_low  = (a_s == (swap ? `PBHA_OFF_DATA_HI : `PBHA_OFF_DATA_LO));

    // page base is page size times page number
    logic [3:0]  shift;
    logic [7:0]  mask, off_eff;
    logic [12:0] base_host, base_own;
    logic [9:0]  byte_addr;
    assign shift     = `PBHA_FULL_SHIFT - {2'b00, page_size_field_in};
    assign mask      = 8'hff >> page_size_field_in;
    assign off_eff   = wmode ? {off_q[7:1], 1'b0} : off_q;             // [R6]
    assign base_host = {8'h00, page_q[4:0]} << shift;                  // [R1]
    assign base_own  = {8'h00, own_node_id_in} << shift;               // [R19]
    assign byte_addr = base_host[9:0] + {2'b00, off_eff & mask};       // [R1]

    // data port access kinds
    logic do_wr, do_rd, split;
    assign do_wr = wr_go & sel_data & ~page_q[`PBHA_BIT_RD];
    assign do_rd = rd_go & sel_data;
    assign split = ~wide & word_access_mode_in;

    // memory port drive
    always_comb begin
        ram_bus.host_word = byte_addr[9:1];
        ram_bus.we        = 1'b0;
        ram_bus.wbe       = 2'b00;
        ram_bus.wdata     = {d_s[7:0], d_s[7:0]};
        if (do_wr) begin
            if (wide) begin
                ram_bus.we    = 1'b1;                                  // [R7]
                ram_bus.wbe   = 2'b11;
                ram_bus.wdata = d_s;
            end else if (split) begin
                ram_bus.we    = ~sel_low;                              // [R9]
                ram_bus.wbe   = 2'b11;
                ram_bus.wdata = {d_s[7:0], hold_q};                    // [R10]
            end else begin
                ram_bus.we    = 1'b1;                                  // [R8]
                ram_bus.wbe   = byte_addr[0] ? 2'b10 : 2'b01;
            end
        end
    end

    // a step follows a whole unit: word, byte, or the high half
    logic       step_go;
    logic [8:0] sum;
    assign step_go = page_q[`PBHA_BIT_STEP] & (do_wr | do_rd) & ~(split & sel_low); // [R20]
    assign sum     = {1'b0, off_eff} + (wmode ? 9'h002 : 9'h001);

    // page select and in-page address registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            page_q <= `PBHA_PAGE_RST;
            off_q  <= `PBHA_ADDR_RST;
        end else if (wr_go && sel_page) begin
            page_q <= d_s[7:0];                                        // [R4]
        end else if (wr_go && sel_addr) begin
            off_q  <= wmode ? {d_s[7:1], 1'b0} : d_s[7:0];             // [R6]
        end else if (step_go) begin
            // without wrap the walk runs on into the next page
            off_q <= sum[7:0] & mask;                                  // [R20]
            if (page_q[`PBHA_BIT_WRAP_N] && sum > {1'b0, mask}) begin
                page_q <= {page_q[7:5], page_q[4:0] + 5'h01};
            end
        end
    end

    // low byte staging for split word writes, high byte staging for split word reads
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= 8'h00;
        end else if (split && sel_low && do_wr) begin
            hold_q <= d_s[7:0];                                        // [R9]
        end else if (split && sel_low && do_rd) begin
            hold_q <= ram_bus.host_rdata[15:8];
        end
    end

    // read data, unmapped offsets answer zero
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (sel_page) begin
            rd_val = {8'h00, page_q};
        end else if (sel_addr) begin
            rd_val = {8'h00, off_q};
        end else if (sel_data) begin
            if (wide) begin
                rd_val = ram_bus.host_rdata;                           // [R7]
            end else if (split) begin
                rd_val = {8'h00, sel_low ? ram_bus.host_rdata[7:0] : hold_q};
            end else begin
                rd_val = {8'h00, byte_addr[0] ? ram_bus.host_rdata[15:8] : ram_bus.host_rdata[7:0]};
            end
        end
    end

    // bus output holds while the read strobe stays low
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_data_out    <= 16'h0000;
            host_data_oe_out <= 1'b0;
        end else begin
            host_data_oe_out <= rd_now;
            if (rd_go) begin
                host_data_out <= rd_val;
            end
        end
    end

    // pointer legal from 03h to the page end
    logic cp_tx_ok, cp_rx_ok;
    assign cp_tx_ok = (ram_bus.eng_rdata[7:0] >= `PBHA_CP_MIN) & (ram_bus.eng_rdata[7:0] <= mask); // [R15]
    assign cp_rx_ok = (rx_pointer_in >= `PBHA_CP_MIN) & (rx_pointer_in <= mask);                  // [R18]

    pbha_send_state_t st_q;
    logic continuous;
    assign continuous       = transmit_mode_select_in & ~single_shot_send_in;
    assign ram_bus.eng_word = base_own[9:1] + ((st_q == PBHA_CP) ? `PBHA_CP_WORD : `PBHA_HDR_WORD);

    // send sequencer: header fetch, pointer check, send
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q                           <= PBHA_IDLE;
            transmitter_available_flag_out <= 1'b1;
            tx_request_out                 <= 1'b0;
            token_pass_out                 <= 1'b0;
            source_node_out                <= 8'h00;
            destination_node_out           <= 8'h00;
            broadcast_out                  <= 1'b0;
        end else begin
            tx_request_out <= 1'b0;
            token_pass_out <= 1'b0;
            case (st_q)
                PBHA_IDLE: begin
                    if (send_command_in) begin
                        transmitter_available_flag_out <= 1'b0;
                        st_q <= PBHA_HDR;
                    end
                end
                PBHA_HDR: begin
                    source_node_out      <= ram_bus.eng_rdata[7:0];    // [R11]
                    destination_node_out <= ram_bus.eng_rdata[15:8];   // [R11]
                    broadcast_out        <= (ram_bus.eng_rdata[15:8] == `PBHA_BCAST_ID); // [R12]
                    st_q <= PBHA_CP;
                end
                PBHA_CP: begin
                    if (cp_tx_ok) begin
                        tx_request_out <= 1'b1;
                        st_q <= PBHA_SEND;
                    end else begin
                        token_pass_out <= 1'b1;                        // [R16]
                        transmitter_available_flag_out <= ~continuous; // [R17]
                        st_q <= continuous ? PBHA_ARMED : PBHA_IDLE;   // [R17]
                    end
                end
                PBHA_SEND: begin
                    if (tx_done_in) begin
                        transmitter_available_flag_out <= ~continuous;
                        st_q <= continuous ? PBHA_ARMED : PBHA_IDLE;
                    end
                end
                PBHA_ARMED: begin
                    // continuous mode resends on every token
                    if (token_arrival_in) begin
                        st_q <= PBHA_HDR;
                    end
                end
                default: begin
                    st_q <= PBHA_IDLE;
                end
            endcase
        end
    end

    // sticky error flags; a new error beats a clear
    logic cp_fail;
    assign cp_fail = (st_q == PBHA_CP) & ~cp_tx_ok;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            send_error_flag_out    <= 1'b0;
            pointer_error_flag_out <= 1'b0;
        end else begin
            send_error_flag_out    <= cp_fail | (send_error_flag_out & ~error_clear_in);    // [R15]
            pointer_error_flag_out <= cp_fail | (pointer_error_flag_out & ~error_clear_in); // [R16]
        end
    end

    // receive side pointer screening
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_discard_out <= 1'b0;
            rx_accept_out  <= 1'b0;
        end else begin
            rx_discard_out <= rx_header_valid_in & ~cp_rx_ok;          // [R18]
            rx_accept_out  <= rx_header_valid_in & cp_rx_ok;
        end
    end
endmodule : pbha_top
`default_nettype wire

// >>> logic/pbha_cfg.svh
// Purpose: constants for the packet buffer host access block
// Assumes: 6-bit host offsets, 1 kbyte buffer held as 512 words
// Notes: every offset, page register bit position and page and address reset value lives here
// What this block and its host do
// R1: buffer pages per node id, base size times id
// R2: host uses node ids from 01h upward
// R3: host sets page and address before data access
// R4: page register with direction, step, wrap, page
// R5: address register at 06h, 07h when swapped
// R6: wide bus or word mode forces even address
// R7: wide bus moves a whole word per access
// R8: narrow byte mode answers at 08h or 09h
// R9: host takes low data offset before high one
// R10: pointer byte reached by a word access, or by a byte access at 08h or 09h in byte mode
// R11: header bytes are source, destination, pointer
// R12: destination zero means broadcast to all nodes
// R13: host writes pointer as page size minus count
// R14: host keeps pointer from 03h to page end
// R15: bad pointer rejected, send and pointer errors set
// R16: after pointer error both flags set, token passed
// R17: transmitter available returns unless continuous remote mode
// R18: receiver discards bad pointer packet, goes idle
// R19: own node id page is the transmit buffer
// R20: auto step by access width, wrap in page
`ifndef PBHA_CFG_SVH
`define PBHA_CFG_SVH
`define PBHA_OFF_PAGE     6'h04
`define PBHA_OFF_PAGE_SW  6'h05
`define PBHA_OFF_ADDR     6'h06
`define PBHA_OFF_ADDR_SW  6'h07
`define PBHA_OFF_DATA_LO  6'h08
`define PBHA_OFF_DATA_HI  6'h09
`define PBHA_BIT_RD       7
`define PBHA_BIT_STEP     6
`define PBHA_BIT_WRAP_N   5
`define PBHA_PAGE_RST     8'h00
`define PBHA_ADDR_RST     8'h00
`define PBHA_CP_MIN       8'h03
`define PBHA_BCAST_ID     8'h00
`define PBHA_FULL_SHIFT   4'h8
`define PBHA_HDR_WORD     9'h000
`define PBHA_CP_WORD      9'h001
`endif

// >>> logic/pbha_pkg.sv
// Purpose: shared types of the packet buffer host access block
// Assumes: nothing beyond the cfg header
// Notes: send sequencer states only
package pbha_pkg;
    typedef enum logic [2:0] {
        PBHA_IDLE,
        PBHA_HDR,
        PBHA_CP,
        PBHA_SEND,
        PBHA_ARMED
    } pbha_send_state_t;
endpackage : pbha_pkg

// >>> logic/pbha_ram_if.sv
// Purpose: carrier between access logic and buffer memory
// Assumes: host port writes, both ports read combinationally
// Notes: engine port is read only
`timescale 1ns/10ps
`default_nettype none
interface pbha_ram_if;
    logic [8:0]  host_word;
    logic [15:0] wdata;
    logic [1:0]  wbe;
    logic        we;
    logic [15:0] host_rdata;
    logic [8:0]  eng_word;
    logic [15:0] eng_rdata;
    modport ctrl (output host_word, wdata, wbe, we, eng_word, input host_rdata, eng_rdata);
    modport mem  (input host_word, wdata, wbe, we, eng_word, output host_rdata, eng_rdata);
endinterface : pbha_ram_if
`default_nettype wire

// >>> logic/pbha_ram.sv
// Purpose: 1 kbyte dual port packet buffer, two byte lanes
// Assumes: single clock, writes from the host port only
// Notes: contents are not reset
`timescale 1ns/10ps
`default_nettype none
module pbha_ram (
    input wire logic ref_clk_in,   // system clock
    pbha_ram_if.mem  ram           // memory side of the carrier
);
    import pbha_pkg::*;
    // one bank per byte lane so each lane has a single writer
    for (genvar b = 0; b < 2; b++) begin : g_lane
        logic [7:0] bank_q [0:511];
        always_ff @(posedge ref_clk_in) begin
            if (ram.we && ram.wbe[b]) begin
                bank_q[ram.host_word] <= ram.wdata[b*8 +: 8];
            end
        end
        assign ram.host_rdata[b*8 +: 8] = bank_q[ram.host_word];
        assign ram.eng_rdata[b*8 +: 8]  = bank_q[ram.eng_word];
    end
endmodule : pbha_ram
`default_nettype wire

// >>> test/pbha_chk.sv
// Purpose: port checks of the send engine and bus enable
// Assumes: single clock, asynchronous active high reset
// Notes: host bus seen only through the read strobe and bus enable
`timescale 1ns/10ps
`default_nettype none
module pbha_chk (
    input wire logic ref_clk_in,                     // clock
    input wire logic rst_in,                         // reset
    input wire logic host_rd_n_in,                   // read strobe
    input wire logic host_data_oe_out,               // bus enable
    input wire logic send_command_in,                // send pulse
    input wire logic tx_done_in,                     // sent pulse
    input wire logic error_clear_in,                 // clear pulse
    input wire logic transmit_mode_select_in,        // remote mode
    input wire logic single_shot_send_in,            // one shot
    input wire logic transmitter_available_flag_out, // idle flag
    input wire logic tx_request_out,                 // send start
    input wire logic token_pass_out,                 // token pass
    input wire logic send_error_flag_out,            // send error
    input wire logic pointer_error_flag_out          // pointer error
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    logic cont, fin;
    // continuous remote mode keeps the idle flag low
    assign cont = transmit_mode_select_in && !single_shot_send_in;
    assign fin  = tx_done_in && !transmitter_available_flag_out;
    // a send taken while idle, and its outcome
    sequence s_start; send_command_in && transmitter_available_flag_out; endsequence
    sequence s_done; tx_request_out || token_pass_out; endsequence
    property p_ta_drop; s_start |=> !transmitter_available_flag_out; endproperty
    a_ta_drop: assert property (p_ta_drop) else $error("idle flag kept after send");
    property p_outcome; s_start |-> ##[3:4] s_done; endproperty
    a_outcome: assert property (p_outcome) else $error("send gave no outcome");
    property p_tp_flags; token_pass_out |-> send_error_flag_out && pointer_error_flag_out; endproperty
    a_tp_flags: assert property (p_tp_flags) else $error("token passed without flags");
    property p_flag_src; $rose(pointer_error_flag_out) |-> token_pass_out; endproperty
    a_flag_src: assert property (p_flag_src) else $error("pointer flag without token pass");
    property p_sticky; pointer_error_flag_out && !error_clear_in |=> pointer_error_flag_out; endproperty
    a_sticky: assert property (p_sticky) else $error("pointer flag lost");
    property p_clear; error_clear_in |=> !send_error_flag_out || token_pass_out; endproperty
    a_clear: assert property (p_clear) else $error("send flag not cleared");
    property p_ta_back; fin && !cont |=> transmitter_available_flag_out; endproperty
    a_ta_back: assert property (p_ta_back) else $error("idle flag not back");
    property p_ta_hold; fin && cont |=> !transmitter_available_flag_out; endproperty
    a_ta_hold: assert property (p_ta_hold) else $error("idle flag back in continuous mode");
    property p_oe_off; host_rd_n_in [*5] |-> !host_data_oe_out; endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven without read");
endmodule : pbha_chk
bind pbha_top pbha_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .host_rd_n_in(host_rd_n_in),
    .host_data_oe_out(host_data_oe_out), .send_command_in(send_command_in), .tx_done_in(tx_done_in),
    .error_clear_in(error_clear_in), .transmit_mode_select_in(transmit_mode_select_in),
    .single_shot_send_in(single_shot_send_in), .tx_request_out(tx_request_out),
    .transmitter_available_flag_out(transmitter_available_flag_out), .token_pass_out(token_pass_out),
    .send_error_flag_out(send_error_flag_out), .pointer_error_flag_out(pointer_error_flag_out)
);
`default_nettype wire

// >>> test/pbha_host_bfm.sv
// Purpose: behavioural host processor on the parallel register bus
// Assumes: strobe low six clocks, high five between accesses
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module pbha_host_bfm (
    input  wire logic        ref_clk_in, // bench clock
    output logic             cs_n_out,   // chip select, low
    output logic             rd_n_out,   // read strobe, low
    output logic             wr_n_out,   // write strobe, low
    output logic      [5:0]  addr_out,   // register offset
    output logic      [15:0] data_out    // write data
);
    // idle bus from time zero, strobes high at reset end
    initial begin
        {cs_n_out, rd_n_out, wr_n_out} = 3'b111;
        addr_out = 6'h3f;
        data_out = 16'ha5c3;
    end
    // one access; spacing is twice the synchroniser minimum
    task automatic acc(input logic wr, input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        #1 cs_n_out = 1'b0;
        addr_out = a;
        data_out = wr ? d : ~data_out;
        {rd_n_out, wr_n_out} = {wr, !wr};
        repeat (6) @(posedge ref_clk_in);
        #1 {cs_n_out, rd_n_out, wr_n_out} = 3'b111;
        data_out = ~data_out;
        addr_out = ~a;
        repeat (4) @(posedge ref_clk_in);
        #1;
    endtask : acc
endmodule : pbha_host_bfm
`default_nettype wire

// >>> test/packet_buffer_host_access_tb.sv
// Purpose: self checking bench of the host access block
// Assumes: host model drives the bus pins, bench drives the mode pins and the engine inputs
// Notes: expected results are queued and matched by a monitor
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_host_access_tb;
    logic        ref_clk_in = 1'b0;
    logic        rst_in, host_cs_n_in, host_rd_n_in, host_wr_n_in, oe_q;
    logic [5:0]  host_addr_in;
    logic [15:0] host_data_in, host_data_out;
    logic        wide_bus_select_in, byte_swap_n_in, word_access_mode_in, transmit_mode_select_in;
    logic        single_shot_send_in, send_command_in, token_arrival_in, tx_done_in, error_clear_in;
    logic [1:0]  page_size_field_in;
    logic [4:0]  own_node_id_in;
    logic [7:0]  rx_pointer_in, source_node_out, destination_node_out, source_node_field, dst;
    logic        rx_header_valid_in, host_data_oe_out, send_error_flag_out, pointer_error_flag_out;
    logic        transmitter_available_flag_out, tx_request_out, token_pass_out, broadcast_out;
    logic        rx_discard_out, rx_accept_out;
    logic [31:0] q[$], r;
    logic [31:0] seed = 32'hf83d;
    logic [7:0]  cps[4] = '{8'h02, 8'h03, 8'h1f, 8'h20};
    int          n_fail = 0, checked = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    pbha_top u_dut (.*);
    pbha_host_bfm u_host (.ref_clk_in(ref_clk_in), .cs_n_out(host_cs_n_in), .rd_n_out(host_rd_n_in),
        .wr_n_out(host_wr_n_in), .addr_out(host_addr_in), .data_out(host_data_in));
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nxt
    task automatic chk(input logic [31:0] got);
        logic [31:0] exp;
        exp = (q.size() != 0) ? q.pop_front() : 32'hffffffff;
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        if (q.size() != 0) n_fail++;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // read note tag 3: all 16 data bits count
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic w);
        q.push_back({w ? 4'h3 : 4'h0, 12'h000, e});
        u_host.acc(1'b0, a, 16'h0000);
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        u_host.acc(1'b1, a, d);
    endtask : wr
    task automatic rx(input logic [7:0] p, input logic ok);
        q.push_back({4'h2, 26'h0, !ok, ok});
        @(posedge ref_clk_in);
        #1 rx_header_valid_in = 1'b1;
        rx_pointer_in = p;
        @(posedge ref_clk_in);
        #1 rx_header_valid_in = 1'b0;
        rx_pointer_in = ~p;
    endtask : rx
    // clear flags first so each note starts clean
    task automatic snd(input logic ok, input logic tok, input logic [7:0] s, input logic [7:0] d);
        int n;
        @(posedge ref_clk_in);
        #1 error_clear_in = 1'b1;
        @(posedge ref_clk_in);
        #1 error_clear_in = 1'b0;
        q.push_back({4'h1, 7'h00, ok, !ok, !ok, !ok, d == 8'h00, s, d});
        {token_arrival_in, send_command_in} = {tok, !tok};
        @(posedge ref_clk_in);
        #1 {token_arrival_in, send_command_in} = 2'b00;
        for (n = 0; n < 20 && !(tx_request_out || token_pass_out); n++) @(posedge ref_clk_in) #1;
        tx_done_in = ok;
        @(posedge ref_clk_in);
        #1 tx_done_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1;
    endtask : snd
    task automatic rst_to(input logic w, input logic sw);
        {rst_in, wide_bus_select_in, byte_swap_n_in} = {1'b1, w, sw};
        repeat (10) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask : rst_to
    // monitor: bus enable rise, engine pulse or rx verdict
    always @(negedge ref_clk_in) begin
        if (host_data_oe_out && !oe_q) begin
            chk((q.size() != 0 && q[0][29]) ? {16'h3000, host_data_out} : {24'h0, host_data_out[7:0]});
        end
        if (tx_request_out || token_pass_out) chk({4'h1, 7'h00, tx_request_out, token_pass_out,
            send_error_flag_out, pointer_error_flag_out, broadcast_out, source_node_out, destination_node_out});
        if (rx_discard_out || rx_accept_out) chk({4'h2, 26'h0, rx_discard_out, rx_accept_out});
        oe_q = host_data_oe_out;
    end
    // 45 accesses of 11 cycles plus engine traffic
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_fail++;
        close_out();
    end
    initial begin
        {send_command_in, token_arrival_in, tx_done_in, error_clear_in, rx_header_valid_in, oe_q} = '0;
        {transmit_mode_select_in, single_shot_send_in, word_access_mode_in} = '0;
        rx_pointer_in = 8'h00;
        page_size_field_in = 2'b11;
        own_node_id_in = 5'd2;
        rst_to(1'b0, 1'b1);
        r = nxt();
        {dst, source_node_field} = r[15:0];
        wr(6'h04, 16'h0042);
        rd(6'h04, 16'h0042, 1'b0);
        wr(6'h06, 16'h0000);
        rd(6'h06, 16'h0000, 1'b0);
        wr(6'h08, {8'h00, source_node_field});
        wr(6'h09, 16'h0000);
        wr(6'h08, 16'h001a);
        wr(6'h04, 16'h00c2);
        wr(6'h06, 16'h0000);
        rd(6'h09, {8'h00, source_node_field}, 1'b0);
        rd(6'h08, 16'h0000, 1'b0);
        rd(6'h08, 16'h001a, 1'b0);
        wr(6'h06, 16'h0000);
        wr(6'h08, {8'h00, ~source_node_field});
        wr(6'h06, 16'h0000);
        rd(6'h08, {8'h00, source_node_field}, 1'b0);
        rd(6'h0a, 16'h0000, 1'b0);
        wr(6'h04, 16'h0002);
        foreach (cps[i]) begin
            wr(6'h06, 16'h0002);
            wr(6'h08, {8'h00, cps[i]});
            snd((cps[i] >= 8'h03) && (cps[i] <= 8'h1f), 1'b0, source_node_field, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            page_size_field_in = 2'(p);
            rx(8'h02, 1'b0);
            rx(8'h03, 1'b1);
            rx(8'hff >> p, 1'b1);
            rx((8'hff >> p) + 8'h01, 1'b0);
        end
        {page_size_field_in, word_access_mode_in} = 3'b111;
        wr(6'h04, 16'h0042);
        wr(6'h06, 16'h0000);
        wr(6'h08, {8'h00, source_node_field});
        wr(6'h09, {8'h00, dst});
        wr(6'h08, 16'h0003);
        wr(6'h09, 16'h0000);
        snd(1'b1, 1'b0, source_node_field, dst);
        wr(6'h04, 16'h00c2);
        wr(6'h06, 16'h0000);
        rd(6'h08, {8'h00, source_node_field}, 1'b0);
        rd(6'h09, {8'h00, dst}, 1'b0);
        word_access_mode_in = 1'b0;
        rst_to(1'b1, 1'b0);
        r = nxt();
        wr(6'h05, 16'h0042);
        wr(6'h07, 16'h0001);
        wr(6'h08, r[15:0]);
        wr(6'h08, 16'h5503);
        snd(1'b1, 1'b0, r[7:0], r[15:8]);
        wr(6'h05, 16'h00c2);
        wr(6'h07, 16'h0000);
        rd(6'h08, r[15:0], 1'b1);
        rd(6'h08, 16'h5503, 1'b1);
        rd(6'h07, 16'h0004, 1'b0);
        transmit_mode_select_in = 1'b1;
        snd(1'b1, 1'b0, r[7:0], r[15:8]);
        single_shot_send_in = 1'b1;
        snd(1'b1, 1'b1, r[7:0], r[15:8]);
        close_out();
    end
endmodule : packet_buffer_host_access_tb
`default_nettype wire
